// file: tccs_pkg.sv
// tccs_pkg: constants for the transceiver clock and calibration setup block
// assumes: included before any tccs module; no other dependencies
package tccs_pkg;
  // ****************************************************************
  // field widths
  // ****************************************************************
  localparam int TCCS_RCNT_W = 3;
  localparam int TCCS_CLKO_W = 4;
  localparam int TCCS_BBOS_W = 2;
  localparam int TCCS_DEMOD_W = 4;
  localparam int TCCS_CDR_W = 8;
  localparam int TCCS_SEQ_W = 8;
  localparam int TCCS_AGC_W = 8;
  localparam int TCCS_DIV_W = 12;
  localparam int TCCS_DEV_W = 9;
  localparam int TCCS_PWR_W = 6;
  localparam int TCCS_RAMP_W = 3;
  localparam int TCCS_TONE_W = 8;
  localparam int TCCS_DWELL_W = 8;
  localparam int TCCS_TRIM_W = 6;
  localparam int TCCS_DBW_W = 10;
  localparam int TCCS_DEVHZ_W = 24;
  // ****************************************************************
  // reset values and limits
  // ****************************************************************
  localparam logic [TCCS_DBW_W-1:0] TCCS_DBW_MAX = 10'h294; // 660
  localparam logic [3:0] TCCS_FINE_DWELLS = 4'ha; // ten dwell periods
  localparam logic [TCCS_PWR_W-1:0] TCCS_LEVEL_RST = 6'h00;
  localparam logic TCCS_ALPHA_RST = 1'b0; // 0.5 roll-off
  localparam int TCCS_DEV_SHIFT = 16;
  // ****************************************************************
  // calibration sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {TCCS_IDLE, TCCS_COARSE, TCCS_FINE} tccs_cal_e;
endpackage

// file: tccs_divider.sv
// tccs_divider: integer divider with a square wave output
// assumes: driving clock is ref_clk; advance gives the input clock's edges
`timescale 1ns/1ns
`default_nettype none
module tccs_divider #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic advance,
  input wire logic [W-1:0] divisor,
  output logic tick,
  output logic wave
);
  logic [W-1:0] count_reg;
  logic [W-1:0] half;
  logic wrap;
  // restart the counter at one when it reaches the divisor, once per output period
  assign wrap = (count_reg == '0) || (count_reg >= divisor);
  assign half = divisor >> 1;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= '0;
      tick <= 1'b0;
      wave <= 1'b0;
    end else begin
      tick <= advance && wrap;
      if (advance) begin
        count_reg <= wrap ? W'(1) : count_reg + W'(1);
        wave <= wrap ? 1'b1 : (count_reg >= half ? 1'b0 : wave);
      end
    end
  end
endmodule // tccs_divider
`default_nettype wire

// file: tccs_top.sv
// tccs_top: clock generation, pa ramp, deviation and if calibration sequencing
// assumes: ref_clk is the crystal reference; settings held stable by the host
// How it works
// - comparison clock is reference over reference count if doubler set, over twice the count if not
// - clock output pin is the reference divided down, then inverted
// - amplifier level steps at the ramp rate until the power level
// - amplifier-on bit ramps the level both up and down
// - direction bit ramps up on enable, cuts off at once on disable
// - roll-off bit selects 0.5 or 0.7, reset gives 0.5
// - baseband offset clock is reference over its divisor, host keeps 1-2 MHz
// - demodulator clock is reference over its divisor, host keeps 2-15 MHz
// - recovery clock divides demodulator clock, host sets near 32x rate
// - sequencer clock is reference over sequencer divisor, about 100 kHz
// - gain update ticks divide sequencer clock, about 3 kHz
// - deviation is code times comparison rate over 2^16, halved if halver on
// - four-level mode gives tones at plus/minus one and three deviations
// - a coarse calibration starts when the coarse trigger is written set while idle
// - an armed fine bit makes fine calibration follow each coarse one
// - fine calibration starts only from a setup write with coarse trigger
// - a stored trim can be applied directly at receiver power-up
// - each tone is the reference over twice its tone divisor
// - each tone lasts the dwell count in sequencer periods
// - fine calibration takes ten tone dwell periods in all
// - source strength from a two-bit field, frequency halved by halve bit
// - status output flags that a calibration has finished
`timescale 1ns/1ns
`default_nettype none
module tccs_top
  import tccs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ref_doubler,
  input wire logic [TCCS_RCNT_W-1:0] ref_divider_count,
  input wire logic [TCCS_CLKO_W-1:0] clock_out_divisor,
  input wire logic [TCCS_BBOS_W-1:0] baseband_offset_divisor,
  input wire logic [TCCS_DEMOD_W-1:0] demodulator_clock_divisor,
  input wire logic [TCCS_CDR_W-1:0] recovery_clock_divisor,
  input wire logic [TCCS_SEQ_W-1:0] sequencer_divisor,
  input wire logic [TCCS_AGC_W-1:0] gain_update_divisor,
  input wire logic amp_on,
  input wire logic tx_direction,
  input wire logic [TCCS_RAMP_W-1:0] ramp_rate,
  input wire logic [TCCS_PWR_W-1:0] power_level,
  input wire logic shaping_rolloff,
  input wire logic [TCCS_DEV_W-1:0] deviation_code,
  input wire logic output_halver,
  input wire logic four_level,
  input wire logic [1:0] symbol_sel,
  input wire logic [TCCS_DBW_W-1:0] discrim_bandwidth,
  input wire logic filter_setup_write,
  input wire logic coarse_trigger,
  input wire logic fine_arm,
  input wire logic trim_use_stored,
  input wire logic [TCCS_TRIM_W-1:0] trim_stored,
  input wire logic rx_power_up,
  input wire logic [TCCS_TONE_W-1:0] low_tone_divisor,
  input wire logic [TCCS_TONE_W-1:0] high_tone_divisor,
  input wire logic [TCCS_DWELL_W-1:0] tone_dwell_count,
  input wire logic [1:0] ir_source_strength,
  input wire logic ir_source_halve,
  output logic phase_compare_freq,
  output logic clock_out_pin,
  output logic baseband_offset_clk,
  output logic demod_clk,
  output logic recovery_clk,
  output logic seq_clk,
  output logic gain_update_tick,
  output logic [TCCS_PWR_W-1:0] amp_level,
  output logic rolloff_07,
  output logic [TCCS_DEVHZ_W-1:0] deviation_step,
  output logic [TCCS_DEVHZ_W-1:0] tone_offset,
  output logic tone_negative,
  output logic discrim_bw_error,
  output logic coarse_busy,
  output logic fine_busy,
  output logic cal_done,
  output logic cal_tone,
  output logic [TCCS_TRIM_W-1:0] trim_applied,
  output logic [1:0] ir_drive,
  output logic ir_clk
);
  // ****************************************************************
  // reference doubler and phase comparison clock
  // ****************************************************************
  logic dblPhase_reg;
  logic refAdv;
  logic pfdTick, pfdWave;
  // doubler set gives one advance every reference cycle, doubler clear one every other cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dblPhase_reg <= 1'b0;
    end else begin
      dblPhase_reg <= ~dblPhase_reg;
    end
  end
  assign refAdv = ref_doubler | dblPhase_reg;
  tccs_divider #(.W(TCCS_DIV_W)) u_pfd (
    .ref_clk(ref_clk),
    .srst(srst),
    .advance(refAdv),
    .divisor({9'h000, ref_divider_count}),
    .tick(pfdTick),
    .wave(pfdWave)
  );

  // ****************************************************************
  // reference-derived clocks
  // ****************************************************************
  logic coWave, bbWave, dmTick, dmWave, cdWave;
  logic sqTick, sqWave, agTick;
  tccs_divider #(.W(TCCS_DIV_W)) u_clko (
    .ref_clk(ref_clk),
    .srst(srst),
    .advance(1'b1),
    .divisor({8'h00, clock_out_divisor}),
    .tick(),
    .wave(coWave)
  );
  tccs_divider #(.W(TCCS_DIV_W)) u_bbos (
    .ref_clk(ref_clk),
    .srst(srst),
    .advance(1'b1),
    .divisor({10'h000, baseband_offset_divisor}),
    .tick(),
    .wave(bbWave)
  );
  tccs_divider #(.W(TCCS_DIV_W)) u_demod (
    .ref_clk(ref_clk), .srst(srst), .advance(1'b1),
    .divisor({8'h00, demodulator_clock_divisor}), .tick(dmTick), .wave(dmWave));
  tccs_divider #(.W(TCCS_DIV_W)) u_cdr (
    .ref_clk(ref_clk),
    .srst(srst),
    .advance(dmTick),
    .divisor({4'h0, recovery_clock_divisor}),
    .tick(),
    .wave(cdWave)
  );
  tccs_divider #(.W(TCCS_DIV_W)) u_seq (
    .ref_clk(ref_clk), .srst(srst), .advance(1'b1),
    .divisor({4'h0, sequencer_divisor}), .tick(sqTick), .wave(sqWave));
  tccs_divider #(.W(TCCS_DIV_W)) u_agc (
    .ref_clk(ref_clk),
    .srst(srst),
    .advance(sqTick),
    .divisor({4'h0, gain_update_divisor}),
    .tick(agTick),
    .wave()
  );

  // register the clock outputs so each leaves from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_compare_freq <= 1'b0;
      clock_out_pin <= 1'b1;
      baseband_offset_clk <= 1'b0;
      demod_clk <= 1'b0;
      recovery_clk <= 1'b0;
      seq_clk <= 1'b0;
      gain_update_tick <= 1'b0;
    end else begin
      phase_compare_freq <= pfdWave;
      clock_out_pin <= ~coWave;
      baseband_offset_clk <= bbWave;
      demod_clk <= dmWave;
      recovery_clk <= cdWave;
      seq_clk <= sqWave;
      gain_update_tick <= agTick;
    end
  end

  // ****************************************************************
  // power amplifier ramp
  // ****************************************************************
  logic [7:0] rampCnt_reg;
  logic [7:0] rampPeriod;
  logic rampStep;
  logic ampTarget;
  logic dirOff;
  logic [TCCS_PWR_W-1:0] level_next;
  // ramp step period in comparison ticks doubles with each rate code less
  assign rampPeriod = 8'h80 >> ramp_rate;
  assign rampStep = pfdTick && (rampCnt_reg >= rampPeriod);
  assign ampTarget = amp_on && tx_direction;
  assign dirOff = amp_on && !tx_direction;
  // up or down toward level, down to zero when amp_on is dropped, hard off on direction
  assign level_next = dirOff ? TCCS_LEVEL_RST :
    !rampStep ? amp_level :
    (ampTarget && amp_level < power_level) ? amp_level + 6'h01 :
    (ampTarget && amp_level > power_level) ? amp_level - 6'h01 :
    (!ampTarget && amp_level != 6'h00) ? amp_level - 6'h01 :
    amp_level;
  // ramp tick counter and amplifier level register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rampCnt_reg <= 8'h00;
      amp_level <= TCCS_LEVEL_RST;
    end else begin
      rampCnt_reg <= rampStep ? 8'h00 : (pfdTick ? rampCnt_reg + 8'h01 : rampCnt_reg);
      amp_level <= level_next;
    end
  end

  // ****************************************************************
  // modulation settings
  // ****************************************************************
  logic [TCCS_DEVHZ_W-1:0] devRaw;
  logic [TCCS_DEVHZ_W-1:0] devFull;
  logic [TCCS_DEVHZ_W-1:0] devStep;
  logic [TCCS_DEVHZ_W-1:0] devTone;
  // deviation in steps of reference over r count over 2^16; the doubler scales it
  assign devRaw = {15'h0000, deviation_code};
  assign devFull = ref_doubler ? (devRaw << 1) : devRaw;
  assign devStep = output_halver ? (devFull >> 1) : devFull;
  // outer symbols use three times the step in four-level mode
  assign devTone = (four_level && symbol_sel[0]) ? devStep * 24'h000003 : devStep;
  // register the modulation, filter and image source settings
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rolloff_07 <= TCCS_ALPHA_RST;
      deviation_step <= '0;
      tone_offset <= '0;
      tone_negative <= 1'b0;
      discrim_bw_error <= 1'b0;
      ir_drive <= 2'h0;
    end else begin
      rolloff_07 <= shaping_rolloff;
      deviation_step <= devStep;
      tone_offset <= devTone;
      tone_negative <= symbol_sel[1];
      discrim_bw_error <= discrim_bandwidth > TCCS_DBW_MAX;
      ir_drive <= ir_source_strength;
    end
  end

  // ****************************************************************
  // if filter calibration sequencer
  // ****************************************************************
  tccs_cal_e state_reg, state_next;
  logic fineArm_reg;
  logic [TCCS_DWELL_W-1:0] dwell_reg;
  logic [3:0] dwellsDone_reg;
  logic startCal;
  logic dwellEnd;
  logic toneHigh;
  logic [TCCS_TONE_W-1:0] toneDiv;
  logic tnTick, tnWave;
  assign startCal = filter_setup_write && coarse_trigger;
  assign dwellEnd = sqTick && (dwell_reg >= tone_dwell_count);
  // odd dwells sit on the upper tone, even ones on the lower
  assign toneHigh = dwellsDone_reg[0];
  assign toneDiv = toneHigh ? high_tone_divisor : low_tone_divisor;
  // tone divider advances on every other reference cycle to give reference over 2x
  tccs_divider #(.W(TCCS_DIV_W)) u_tone (
    .ref_clk(ref_clk), .srst(srst), .advance(dblPhase_reg),
    .divisor({4'h0, toneDiv}), .tick(tnTick), .wave(tnWave));
  // coarse takes one dwell, fine runs ten dwells
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TCCS_IDLE: begin
        if (startCal) begin
          state_next = TCCS_COARSE;
        end
      end
      TCCS_COARSE: begin
        if (dwellEnd) begin
          state_next = fineArm_reg ? TCCS_FINE : TCCS_IDLE;
        end
      end
      TCCS_FINE: begin
        if (dwellEnd && dwellsDone_reg == TCCS_FINE_DWELLS - 4'h1) begin
          state_next = TCCS_IDLE;
        end
      end
      default: begin
        state_next = TCCS_IDLE;
      end
    endcase
  end
  // sequencer state, dwell counter and done flag
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= TCCS_IDLE;
      fineArm_reg <= 1'b0;
      dwell_reg <= '0;
      dwellsDone_reg <= 4'h0;
      cal_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      fineArm_reg <= fine_arm; // arming alone starts nothing
      if (state_reg == TCCS_IDLE || dwellEnd) begin
        dwell_reg <= 8'h01; // a dwell spans exactly the dwell count of ticks
      end else if (sqTick) begin
        dwell_reg <= dwell_reg + 8'h01;
      end
      if (state_reg != TCCS_FINE) begin
        dwellsDone_reg <= 4'h0;
      end else if (dwellEnd) begin
        dwellsDone_reg <= dwellsDone_reg + 4'h1;
      end
      // finish sets the flag, a new start clears it; finish wins
      if (state_reg != TCCS_IDLE && state_next == TCCS_IDLE) begin
        cal_done <= 1'b1;
      end else if (startCal) begin
        cal_done <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // trim, tone and image source outputs
  // ****************************************************************
  logic irHalf_reg;
  logic [TCCS_TRIM_W-1:0] trimCal_reg;
  // busy flags, gated tone, trim pick-up and image source divider
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      coarse_busy <= 1'b0;
      fine_busy <= 1'b0;
      cal_tone <= 1'b0;
      trim_applied <= '0;
      trimCal_reg <= '0;
      irHalf_reg <= 1'b0;
      ir_clk <= 1'b0;
    end else begin
      coarse_busy <= state_next == TCCS_COARSE;
      fine_busy <= state_next == TCCS_FINE;
      cal_tone <= (state_reg == TCCS_FINE) && tnWave;
      if (state_reg == TCCS_FINE && dwellEnd) begin
        trimCal_reg <= trimCal_reg + 6'h01;
      end
      if (rx_power_up) begin
        trim_applied <= trim_use_stored ? trim_stored : trimCal_reg;
      end
      if (tnTick) begin
        irHalf_reg <= ~irHalf_reg;
      end
      ir_clk <= ir_source_halve ? irHalf_reg : tnWave;
    end
  end
endmodule // tccs_top
`default_nettype wire

// file: tccs_top_props.sv
// tccs_top_props: port-level checks on the clock and calibration block
// assumes: bound to tccs_top from the bench top file
`timescale 1ns/1ns
`default_nettype none
module tccs_top_props
  import tccs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic amp_on,
  input wire logic tx_direction,
  input wire logic shaping_rolloff,
  input wire logic [TCCS_DBW_W-1:0] discrim_bandwidth,
  input wire logic filter_setup_write,
  input wire logic coarse_trigger,
  input wire logic [TCCS_PWR_W-1:0] amp_level,
  input wire logic rolloff_07,
  input wire logic discrim_bw_error,
  input wire logic coarse_busy,
  input wire logic fine_busy,
  input wire logic cal_done
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // sequencer idle, start request and hard cut-off condition
  wire calIdle = !coarse_busy && !fine_busy;
  wire calStart = filter_setup_write && coarse_trigger;
  wire cutOff = amp_on && !tx_direction;
  a_start_busy: assert property (calIdle && calStart |=> coarse_busy && !cal_done)
    else $error("coarse run did not start");
  a_no_start: assert property (calIdle && !calStart |=> !coarse_busy && !fine_busy)
    else $error("calibration started without a trigger write");
  a_fine_after: assert property ($rose(fine_busy) |-> $past(coarse_busy))
    else $error("fine run not preceded by coarse run");
  a_done_end: assert property ($fell(coarse_busy || fine_busy) ##1 calIdle |-> ##[0:2] cal_done)
    else $error("done flag missing after calibration");
  a_hard_cut: assert property (cutOff |-> ##[1:2] (amp_level == 6'h00))
    else $error("amplifier not cut off");
  a_ramp_step: assert property (!$past(cutOff) && !$past(cutOff, 2) && $changed(amp_level)
    |-> amp_level == $past(amp_level) + 6'h01 || amp_level == $past(amp_level) - 6'h01)
    else $error("amplifier level jumped");
  a_bw_flag: assert property (!$past(srst) && $stable(discrim_bandwidth)
    |-> discrim_bw_error == (discrim_bandwidth > TCCS_DBW_MAX))
    else $error("bandwidth flag wrong");
  a_rolloff_sel: assert property (!$past(srst) && $stable(shaping_rolloff)
    |-> rolloff_07 == shaping_rolloff)
    else $error("roll-off select wrong");
  c_start: cover property (calIdle && calStart);
  c_fine: cover property ($rose(fine_busy));
  c_ramp_down: cover property ($fell(amp_level != 6'h00));
endmodule // tccs_top_props
`default_nettype wire

// file: tccs_host_model.sv
// tccs_host_model: host side that writes the filter setup register
// assumes: bench raises go for one rising edge per write
`timescale 1ns/1ns
`default_nettype none
module tccs_host_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic with_coarse,
  input wire logic arm,
  output var logic filter_setup_write = 1'h0,
  output var logic coarse_trigger = 1'h0,
  output var logic fine_arm = 1'h0
);
  logic pend = 1'h0;
  // latch the request at the rising edge
  always @(posedge ref_clk) pend <= go;
  // present one whole write cycle between falling edges
  always @(negedge ref_clk) begin
    filter_setup_write <= pend;
    coarse_trigger <= with_coarse;
    fine_arm <= arm;
  end
endmodule // tccs_host_model
`default_nettype wire

// file: tccs_top_test.sv
// tccs_top_test: self-checking bench for the clock and calibration block
// assumes: tccs_pkg, tccs_top, tccs_host_model, tccs_top_props compiled first
`timescale 1ns/1ns
`default_nettype none
module tccs_top_test;
  import tccs_pkg::*;
  // ****
  // stimulus and observation
  // ****
  logic ref_clk = 1'h0, srst = 1'h1, ref_doubler = 1'h1, amp_on = 1'h0, tx_direction = 1'h0;
  logic shaping_rolloff = 1'h0, output_halver = 1'h0, four_level = 1'h0, trim_use_stored = 1'h0;
  logic rx_power_up = 1'h0, ir_source_halve = 1'h0, go = 1'h0, with_coarse = 1'h1, arm = 1'h0;
  logic [2:0] ref_divider_count = 3'h3, ramp_rate = 3'h7;
  logic [3:0] clock_out_divisor = 4'h4, demodulator_clock_divisor = 4'h2;
  logic [1:0] baseband_offset_divisor = 2'h3, symbol_sel = 2'h0, ir_source_strength = 2'h0;
  logic [7:0] recovery_clock_divisor = 8'h03, sequencer_divisor = 8'h05;
  logic [7:0] gain_update_divisor = 8'h02, tone_dwell_count = 8'h04;
  logic [7:0] low_tone_divisor = 8'h04, high_tone_divisor = 8'h03;
  logic [5:0] power_level = 6'h05, trim_stored = 6'h2a, amp_level, trim_applied;
  logic [8:0] deviation_code = 9'h101;
  logic [9:0] discrim_bandwidth = 10'h000;
  logic filter_setup_write, coarse_trigger, fine_arm, phase_compare_freq, clock_out_pin, ir_clk;
  logic baseband_offset_clk, demod_clk, recovery_clk, seq_clk, gain_update_tick, rolloff_07;
  logic tone_negative, discrim_bw_error, coarse_busy, fine_busy, cal_done, cal_tone;
  logic [23:0] deviation_step, tone_offset;
  logic [1:0] ir_drive;
  int failures = 0, comparisons = 0;
  // outputs watched by the wait helper, by index
  wire [13:0] obs = {ir_clk, cal_tone, amp_level == 6'h00, amp_level == power_level, cal_done,
    fine_busy, coarse_busy, gain_update_tick, seq_clk, recovery_clk, demod_clk,
    baseband_offset_clk, clock_out_pin, phase_compare_freq};
  // reference clock
  always #50 ref_clk = ~ref_clk;
  tccs_top dut (.ref_clk, .srst, .ref_doubler, .ref_divider_count, .clock_out_divisor,
    .baseband_offset_divisor, .demodulator_clock_divisor, .recovery_clock_divisor,
    .sequencer_divisor, .gain_update_divisor, .amp_on, .tx_direction, .ramp_rate, .power_level,
    .shaping_rolloff, .deviation_code, .output_halver, .four_level, .symbol_sel,
    .discrim_bandwidth, .filter_setup_write, .coarse_trigger, .fine_arm, .trim_use_stored,
    .trim_stored, .rx_power_up, .low_tone_divisor, .high_tone_divisor, .tone_dwell_count,
    .ir_source_strength, .ir_source_halve, .phase_compare_freq, .clock_out_pin,
    .baseband_offset_clk, .demod_clk, .recovery_clk, .seq_clk, .gain_update_tick, .amp_level,
    .rolloff_07, .deviation_step, .tone_offset, .tone_negative, .discrim_bw_error, .coarse_busy,
    .fine_busy, .cal_done, .cal_tone, .trim_applied, .ir_drive, .ir_clk);
  tccs_host_model host (.ref_clk, .go, .with_coarse, .arm, .filter_setup_write,
    .coarse_trigger, .fine_arm);
  // ****
  // helpers
  // ****
  task automatic report_and_stop;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic waitv(input int s, input logic v, inout int n);
    while (obs[s] !== v) begin
      @(negedge ref_clk);
      n++;
      if (n > 4000) begin
        failures++;
        report_and_stop();
      end
    end
  endtask
  task automatic per(input int s, input int e);
    int n = 0;
    int t;
    waitv(s, 1'h0, n);
    waitv(s, 1'h1, n);
    t = n;
    waitv(s, 1'h0, n);
    waitv(s, 1'h1, n);
    chk($sformatf("period%0d", s), 24'(e), 24'(n - t));
  endtask
  task automatic go_pulse;
    go = 1'h1;
    idle(1);
    go = 1'h0;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_clocks;
    int n = 0;
    per(0, 3);
    per(1, 4);
    per(2, 3);
    per(3, 2);
    per(4, 6);
    per(5, 5);
    repeat (100) begin
      @(negedge ref_clk);
      n += int'(gain_update_tick === 1'h1);
    end
    chk("gain_ticks", 24'h00000a, 24'(n));
    ref_doubler = 1'h0;
    clock_out_divisor = 4'h5;
    idle(30);
    per(0, 6);
    per(1, 5);
  endtask
  task automatic t_ramp;
    int n = 0;
    amp_on = 1'h1;
    tx_direction = 1'h1;
    waitv(10, 1'h1, n);
    idle(20);
    chk("level_held", 24'h5, 24'(amp_level));
    amp_on = 1'h0;
    idle(2);
    chk("ramp_down", 24'h1, 24'(amp_level != 6'h00));
    waitv(11, 1'h1, n);
    amp_on = 1'h1;
    waitv(10, 1'h1, n);
    tx_direction = 1'h0;
    idle(2);
    chk("hard_off", 24'h0, 24'(amp_level));
    amp_on = 1'h0;
  endtask
  task automatic t_dev;
    ref_doubler = 1'h1;
    idle(3);
    chk("dev_step", 24'h000202, deviation_step);
    output_halver = 1'h1;
    idle(3);
    chk("dev_half", 24'h000101, deviation_step);
    four_level = 1'h1;
    for (int i = 0; i < 4; i++) begin
      symbol_sel = 2'(i);
      idle(3);
      chk("tone", i[0] ? 24'h000303 : 24'h000101, tone_offset);
      chk("tone_sign", 24'(i[1]), 24'(tone_negative));
    end
  endtask
  task automatic t_misc;
    shaping_rolloff = 1'h1;
    discrim_bandwidth = 10'h295;
    trim_use_stored = 1'h1;
    rx_power_up = 1'h1;
    idle(1);
    rx_power_up = 1'h0;
    idle(3);
    chk("rolloff", 24'h1, 24'(rolloff_07));
    chk("bw_over", 24'h1, 24'(discrim_bw_error));
    chk("trim", 24'h00002a, 24'(trim_applied));
    discrim_bandwidth = 10'h294;
    shaping_rolloff = 1'h0;
    idle(3);
    chk("bw_max", 24'h0, 24'(discrim_bw_error));
    chk("rolloff", 24'h0, 24'(rolloff_07));
    for (int i = 0; i < 4; i++) begin
      ir_source_strength = 2'(i);
      ir_source_halve = i[0];
      idle(3);
      chk("ir_drive", 24'(i), 24'(ir_drive));
    end
    idle(20);
    per(13, 16);
    ir_source_halve = 1'h0;
    idle(20);
    per(13, 8);
  endtask
  task automatic t_cal;
    int n = 0;
    arm = 1'h1;
    with_coarse = 1'h0;
    go_pulse();
    idle(40);
    chk("no_start", 24'h0, 24'(obs[9:7]));
    with_coarse = 1'h1;
    arm = 1'h0;
    go_pulse();
    waitv(7, 1'h1, n);
    idle(14);
    go_pulse();
    n = 15;
    waitv(7, 1'h0, n);
    chk("coarse_len", 24'h1, 24'(n >= 16 && n <= 20));
    chk("no_fine", 24'h0, 24'(fine_busy));
    n = 0;
    waitv(9, 1'h1, n);
    chk("done_soon", 24'h1, 24'(n <= 2));
    arm = 1'h1;
    go_pulse();
    waitv(8, 1'h1, n);
    n = 0;
    waitv(12, 1'h1, n);
    chk("tone_on", 24'h1, 24'(n <= 9));
    waitv(8, 1'h0, n);
    chk("fine_len", 24'h1, 24'(n >= 190 && n <= 215));
    idle(3);
    chk("done", 24'h1, 24'(cal_done));
    chk("tone_off", 24'h0, 24'(cal_tone));
  endtask
  // main sequence: reset levels, then each scenario
  initial begin
    idle(6);
    chk("rst_clock_out_pin", 24'h1, 24'(clock_out_pin));
    chk("rst_level", 24'h0, 24'(amp_level));
    chk("rst_rolloff", 24'h0, 24'(rolloff_07));
    srst = 1'h0;
    t_clocks();
    t_ramp();
    t_dev();
    t_misc();
    t_cal();
    report_and_stop();
  end
endmodule // tccs_top_test
bind tccs_top tccs_top_props props (.ref_clk, .srst, .amp_on, .tx_direction, .shaping_rolloff,
  .discrim_bandwidth, .filter_setup_write, .coarse_trigger, .amp_level, .rolloff_07,
  .discrim_bw_error, .coarse_busy, .fine_busy, .cal_done);
`default_nettype wire
